// file: pfs_pkg.sv
// Purpose: constants for the general pin function select block
// Assumes: 100 MHz clock, classic Wishbone with 32-bit data
// Notes: operation summary below
// Operation
// - pulse-width and tone outputs exist only on general pins 12, 13 and 17.
// - no more than three pins drive tone or pulse-width at once.
// - plain inputs except pin 19 come up pulled up; pins 14 and 16 stay unpulled until REG_DIR is written; pull-up can be turned off per pin.
// - pin 1 comes up as an output driven high.
// - pin 2 comes up as an output driven low.
// - pin 3 comes up as an input with pull-up.
// - every reset restores all pin defaults.
// - each pin is input with pull-up, input without pull, or output.
// - a pin on an alternate function never gets the internal pull-up.
// - handshake lines count as asserted at the low level.
// - serial receive and transmit rest high while idle.
// - run-mode strap sampled at reset; low with script starts it, high gives interactive.
// - the block reports ready 1.6 s after power-up or soft reset.
package pfs_pkg;
    localparam int NPINS = 21;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PIN_IN = 8'h08;
    localparam logic [7:0] REG_OUT_LVL = 8'h0C;
    localparam logic [7:0] REG_DIR = 8'h10;
    localparam logic [7:0] REG_PULL = 8'h14;
    localparam logic [7:0] REG_ALT = 8'h18;
    localparam logic [7:0] REG_WAVE = 8'h1C;
    localparam int CTRL_SOFT_RST = 0;
    localparam int CTRL_FACTORY = 1;
    localparam int ST_READY = 0;
    localparam int ST_STRAP = 1;
    localparam int ST_AUTORUN = 2;
    localparam int ST_INTERACTIVE = 3;
    localparam int ST_CTS_ACT = 4;
    localparam int ST_CFG14 = 5;
    localparam int ST_CFG16 = 6;
    localparam int WAVE_EN_LSB = 0;
    localparam int WAVE_TONE_LSB = 3;
    localparam int WAVE_LANES = 3;
    localparam int PIN_TX = 1;
    localparam int PIN_RTS = 2;
    localparam int PIN_RX = 0;
    localparam int PIN_CTS = 3;
    localparam int PIN_CFG_A = 14;
    localparam int PIN_CFG_B = 16;
    localparam int PIN_DL = 19;
    localparam int WAVE_PIN0 = 12;
    localparam int WAVE_PIN1 = 13;
    localparam int WAVE_PIN2 = 17;
    localparam logic [20:0] DIR_RST = 21'h000006;
    localparam logic [20:0] OUT_RST = 21'h000002;
    localparam logic [20:0] PULL_RST = 21'h17FFF9;
    localparam logic [20:0] ALT_RST = 21'h000000;
    localparam logic [5:0] WAVE_RST = 6'h00;
    localparam int CLK_MHZ = 100;
    localparam int RST_MIN_NS = 500;
    localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STARTUP_MS = 1600;
    localparam int STARTUP_CYC = STARTUP_MS * CLK_MHZ * 1000;
    localparam int STRAP_WAIT = 3;
endpackage

// file: pfs_pin_select.sv
// Purpose: general pin defaults, direction, pull and alternate function routing
// Assumes: pin levels arrive asynchronously; peripheral signals share CLK
// Notes: registers reached over classic Wishbone, one wait state per access
`timescale 1ns/100ps
module pfs_pin_select
    import pfs_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
)
(
    input wire logic CLK, // system clock
    input wire logic SYS_RST, // async reset, active high
    input wire logic WB_CYC_I, // bus cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write enable
    input wire logic [7:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    input wire logic [20:0] PIN_IN, // pin levels
    output logic [20:0] PIN_OUT, // pin drive levels
    output logic [20:0] PIN_OE, // pin drive enables
    output logic [20:0] PIN_PU, // internal pull-up enables
    input wire logic RUN_MODE_STRAP_N, // run-mode strap pin
    input wire logic MODULE_RST_PIN_LOW, // module reset pin, active low
    input wire logic SCRIPT_PRESENT, // stored startup script exists
    input wire logic UART_TXD, // serial transmit from uart
    input wire logic UART_RTS_ACT, // uart wants rts asserted
    input wire logic PWM_IN, // pulse-width source
    input wire logic TONE_IN, // tone source
    input wire logic [20:0] ALT_OUT, // other alternate drive levels
    input wire logic [20:0] ALT_OE, // other alternate drive enables
    output logic UART_RXD, // serial receive to uart
    output logic UART_CTS_ACT, // cts asserted
    output logic READY, // ready for commands
    output logic AUTORUN_GO, // start stored script
    output logic INTERACTIVE // interactive mode
);
    logic [20:0] pin_s1, pin_s2;
    logic strap_s1, strap_s2, rstp_s1, rstp_s2;
    logic [20:0] lvl, dir, pull, alt, next_lvl, next_dir, next_pull, next_alt;
    logic [5:0] wave, next_wave;
    logic cfg14, cfg16, next_cfg14, next_cfg16;
    logic [31:0] rdata;
    logic next_ack, bus_wr;
    logic [31:0] wmask;
    logic [7:0] rst_cnt, next_rst_cnt;
    logic pin_rst, soft_rst;
    logic [31:0] up_cnt, next_up_cnt;
    logic [1:0] strap_wait, next_strap_wait;
    logic strap_val, next_strap_val, next_autorun, next_inter, next_ready;
    logic [20:0] next_pout, next_poe, next_ppu;
    logic next_rxd, next_cts;

    // asynchronous pins pass two flops before anything reads them
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pin_s1 <= 21'h1FFFFF;
            pin_s2 <= 21'h1FFFFF;
            strap_s1 <= 1'b1;
            strap_s2 <= 1'b1;
            rstp_s1 <= 1'b1;
            rstp_s2 <= 1'b1;
        end
        else
        begin
            pin_s1 <= PIN_IN;
            pin_s2 <= pin_s1;
            strap_s1 <= RUN_MODE_STRAP_N;
            strap_s2 <= strap_s1;
            rstp_s1 <= MODULE_RST_PIN_LOW;
            rstp_s2 <= rstp_s1;
        end
    end

    // a shorter low pulse is treated as a glitch, not a reset
    always_comb
    begin
        next_rst_cnt = rst_cnt;
        pin_rst = 1'b0;
        if (rstp_s2)
        begin
            next_rst_cnt = 8'h00;
        end
        else if (rst_cnt < 8'(RST_MIN_CYC))
        begin
            next_rst_cnt = rst_cnt + 8'h01;
            pin_rst = (rst_cnt == 8'(RST_MIN_CYC - 1));
        end
    end

    assign bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
    assign soft_rst = pin_rst || (bus_wr && WB_ADR_I == REG_CTRL && WB_SEL_I[0]
                      && (WB_DAT_I[CTRL_SOFT_RST] || WB_DAT_I[CTRL_FACTORY]));

    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_mask
            assign wmask[8*b +: 8] = {8{WB_SEL_I[b]}};
        end
    endgenerate

    // configuration registers; writes land on the acknowledging edge
    always_comb
    begin
        next_lvl = lvl;
        next_dir = dir;
        next_pull = pull;
        next_alt = alt;
        next_wave = wave;
        next_cfg14 = cfg14;
        next_cfg16 = cfg16;
        if (soft_rst)
        begin
            next_lvl = OUT_RST;
            next_dir = DIR_RST;
            next_pull = PULL_RST;
            next_alt = ALT_RST;
            next_wave = WAVE_RST;
            next_cfg14 = 1'b0;
            next_cfg16 = 1'b0;
        end
        else if (bus_wr)
        begin
            if (WB_ADR_I == REG_OUT_LVL)
            begin
                next_lvl = (lvl & ~wmask[20:0]) | (WB_DAT_I[20:0] & wmask[20:0]);
            end
            else if (WB_ADR_I == REG_DIR)
            begin
                next_dir = (dir & ~wmask[20:0]) | (WB_DAT_I[20:0] & wmask[20:0]);
                next_cfg14 = cfg14 || WB_SEL_I[1];
                next_cfg16 = cfg16 || WB_SEL_I[2];
            end
            else if (WB_ADR_I == REG_PULL)
            begin
                next_pull = (pull & ~wmask[20:0]) | (WB_DAT_I[20:0] & wmask[20:0]);
            end
            else if (WB_ADR_I == REG_ALT)
            begin
                next_alt = (alt & ~wmask[20:0]) | (WB_DAT_I[20:0] & wmask[20:0]);
            end
            else if (WB_ADR_I == REG_WAVE && WB_SEL_I[0])
            begin
                // only three lanes exist, so at most three wave pins ever drive
                next_wave = WB_DAT_I[5:0];
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            lvl <= OUT_RST;
            dir <= DIR_RST;
            pull <= PULL_RST;
            alt <= ALT_RST;
            wave <= WAVE_RST;
            cfg14 <= 1'b0;
            cfg16 <= 1'b0;
            rst_cnt <= 8'h00;
        end
        else
        begin
            lvl <= next_lvl;
            dir <= next_dir;
            pull <= next_pull;
            alt <= next_alt;
            wave <= next_wave;
            cfg14 <= next_cfg14;
            cfg16 <= next_cfg16;
            rst_cnt <= next_rst_cnt;
        end
    end

    // per-pin routing
    generate
        for (genvar i = 0; i < NPINS; i++)
        begin : g_pin
            localparam int LANE = (i == WAVE_PIN0) ? 0 : (i == WAVE_PIN1) ? 1 : (i == WAVE_PIN2) ? 2 : -1;
            localparam bit NEED_CFG = (i == PIN_CFG_A) || (i == PIN_CFG_B);
            logic wave_on, tone_sel, gpio_ok;
            if (LANE >= 0)
            begin : g_w
                assign wave_on = wave[WAVE_EN_LSB + LANE];
                assign tone_sel = wave[WAVE_TONE_LSB + LANE];
            end
            else
            begin : g_nw
                assign wave_on = 1'b0;
                assign tone_sel = 1'b0;
            end
            if (NEED_CFG)
            begin : g_c
                assign gpio_ok = (i == PIN_CFG_A) ? cfg14 : cfg16;
            end
            else
            begin : g_nc
                assign gpio_ok = 1'b1;
            end
            always_comb
            begin
                next_pout[i] = 1'b0;
                next_poe[i] = 1'b0;
                next_ppu[i] = 1'b0;
                if (wave_on)
                begin
                    next_poe[i] = 1'b1;
                    next_pout[i] = tone_sel ? TONE_IN : PWM_IN;
                end
                else if (alt[i])
                begin
                    // alternate functions never get the internal pull-up
                    if (i == PIN_TX)
                    begin
                        next_poe[i] = 1'b1;
                        next_pout[i] = UART_TXD;
                    end
                    else if (i == PIN_RTS)
                    begin
                        next_poe[i] = 1'b1;
                        next_pout[i] = !UART_RTS_ACT;
                    end
                    else if (i != PIN_RX && i != PIN_CTS)
                    begin
                        next_poe[i] = ALT_OE[i];
                        next_pout[i] = ALT_OUT[i];
                    end
                end
                else if (gpio_ok)
                begin
                    next_poe[i] = dir[i];
                    next_pout[i] = lvl[i];
                    next_ppu[i] = pull[i] && !dir[i];
                end
            end
        end
    endgenerate

    // serial receive rests high whenever the pin is not routed to the uart
    assign next_rxd = alt[PIN_RX] ? pin_s2[PIN_RX] : 1'b1;
    assign next_cts = alt[PIN_CTS] && !pin_s2[PIN_CTS];

    // startup timer and strap capture, both restarted by a soft reset
    always_comb
    begin
        next_up_cnt = up_cnt;
        next_strap_wait = strap_wait;
        next_strap_val = strap_val;
        next_ready = READY;
        next_autorun = AUTORUN_GO;
        next_inter = INTERACTIVE;
        if (soft_rst)
        begin
            next_up_cnt = 32'h00000000;
            next_strap_wait = 2'h0;
            next_ready = 1'b0;
            next_autorun = 1'b0;
            next_inter = 1'b0;
        end
        else
        begin
            if (up_cnt < 32'(STARTUP_CYCLES))
            begin
                next_up_cnt = up_cnt + 32'h00000001;
            end
            next_ready = (up_cnt >= 32'(STARTUP_CYCLES));
            // wait until the synchroniser holds a post-reset sample
            if (strap_wait < 2'(STRAP_WAIT))
            begin
                next_strap_wait = strap_wait + 2'h1;
                if (strap_wait == 2'(STRAP_WAIT - 1))
                begin
                    next_strap_val = strap_s2;
                    next_autorun = !strap_s2 && SCRIPT_PRESENT;
                    next_inter = strap_s2;
                end
            end
        end
    end

    // bus read data
    always_comb
    begin
        rdata = 32'h00000000;
        if (WB_ADR_I == REG_STATUS)
        begin
            rdata[ST_READY] = READY;
            rdata[ST_STRAP] = strap_val;
            rdata[ST_AUTORUN] = AUTORUN_GO;
            rdata[ST_INTERACTIVE] = INTERACTIVE;
            rdata[ST_CTS_ACT] = UART_CTS_ACT;
            rdata[ST_CFG14] = cfg14;
            rdata[ST_CFG16] = cfg16;
        end
        else if (WB_ADR_I == REG_PIN_IN)
        begin
            rdata[20:0] = pin_s2;
        end
        else if (WB_ADR_I == REG_OUT_LVL)
        begin
            rdata[20:0] = lvl;
        end
        else if (WB_ADR_I == REG_DIR)
        begin
            rdata[20:0] = dir;
        end
        else if (WB_ADR_I == REG_PULL)
        begin
            rdata[20:0] = pull;
        end
        else if (WB_ADR_I == REG_ALT)
        begin
            rdata[20:0] = alt;
        end
        else if (WB_ADR_I == REG_WAVE)
        begin
            rdata[5:0] = wave;
        end
    end

    assign next_ack = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            PIN_OUT <= OUT_RST;
            PIN_OE <= DIR_RST;
            PIN_PU <= 21'h000000;
            UART_RXD <= 1'b1;
            UART_CTS_ACT <= 1'b0;
            up_cnt <= 32'h00000000;
            strap_wait <= 2'h0;
            strap_val <= 1'b1;
            READY <= 1'b0;
            AUTORUN_GO <= 1'b0;
            INTERACTIVE <= 1'b0;
        end
        else
        begin
            WB_ACK_O <= next_ack;
            WB_DAT_O <= next_ack ? rdata : 32'h00000000;
            PIN_OUT <= next_pout;
            PIN_OE <= next_poe;
            PIN_PU <= next_ppu;
            UART_RXD <= next_rxd;
            UART_CTS_ACT <= next_cts;
            up_cnt <= next_up_cnt;
            strap_wait <= next_strap_wait;
            strap_val <= next_strap_val;
            READY <= next_ready;
            AUTORUN_GO <= next_autorun;
            INTERACTIVE <= next_inter;
        end
    end
endmodule // pfs_pin_select

// file: pfs_chk.sv
// Purpose: port assertions for the pin function select block
// Assumes: one clock, async active-high reset
// Notes: control writes restart the ready window count
`timescale 1ns/100ps
module pfs_chk
    import pfs_pkg::*;
#(
    parameter int STARTUP_CYCLES = 20
)
(
    input wire logic CLK, // clock
    input wire logic SYS_RST, // reset
    input wire logic WB_CYC_I, // cycle
    input wire logic WB_STB_I, // strobe
    input wire logic WB_WE_I, // write
    input wire logic [7:0] WB_ADR_I, // address
    input wire logic [31:0] WB_DAT_O, // read data
    input wire logic WB_ACK_O, // ack
    input wire logic [20:0] PIN_IN, // levels
    input wire logic [20:0] PIN_OUT, // drive
    input wire logic [20:0] PIN_OE, // enables
    input wire logic [20:0] PIN_PU, // pull-ups
    input wire logic UART_RXD, // rx
    input wire logic UART_CTS_ACT, // cts
    input wire logic READY, // ready
    input wire logic AUTORUN_GO, // autorun
    input wire logic INTERACTIVE, // interactive
    input wire logic MODULE_RST_PIN_LOW // module reset pin, active low
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [7:0] pc;
    logic [7:0] next_pc;
    // counts the raw reset pin; the block counts it after its synchroniser, so the restart here
    // comes one edge early, which the ready window absorbs
    always_comb
        next_pc = MODULE_RST_PIN_LOW ? 8'h00 : (pc == 8'hFF) ? pc : pc + 8'h01;
    // a soft reset restarts the startup timer, so the window restarts too
    always_comb
        next_cnt = ((WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00) || pc == 8'(RST_MIN_CYC)) ? 32'h0 : cnt + 32'h1;
    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            cnt <= 32'h0;
            pc <= 8'h00;
        end
        else
        begin
            cnt <= next_cnt;
            pc <= next_pc;
        end
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ack_follows_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
    rst_drive_a: assert property ($fell(SYS_RST) |-> PIN_OE == 21'h000006 && PIN_OUT == 21'h000002)
        else $error("reset drive wrong");
    rst_pull_a: assert property ($fell(SYS_RST) |=> PIN_PU == 21'h16BFF9) else $error("reset pull wrong");
    pull_input_a: assert property ((PIN_PU & PIN_OE) == 21'h0) else $error("pull on output");
    cts_low_a: assert property (UART_CTS_ACT |-> !$past(PIN_IN[3], 3)) else $error("cts not low");
    rx_idle_a: assert property (!UART_RXD |-> !$past(PIN_IN[0], 3)) else $error("rx not idle");
    mode_excl_a: assert property (!(AUTORUN_GO && INTERACTIVE)) else $error("two modes");
    ready_time_a: assert property ($rose(READY) |-> cnt >= STARTUP_CYCLES && cnt <= STARTUP_CYCLES + 2)
        else $error("ready off time");
endmodule // pfs_chk
bind pfs_pin_select pfs_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PU(PIN_PU),
    .UART_RXD(UART_RXD), .UART_CTS_ACT(UART_CTS_ACT), .READY(READY), .AUTORUN_GO(AUTORUN_GO),
    .INTERACTIVE(INTERACTIVE), .MODULE_RST_PIN_LOW(MODULE_RST_PIN_LOW));

// file: pfs_board.sv
// Purpose: board and host side of the general pins
// Assumes: host drives chosen pins, board holds resistors
// Notes: a pin nobody drives or pulls flips every cycle
`timescale 1ns/100ps
module pfs_board
(
    input wire logic clk, // clock
    input wire logic [20:0] pin_out, // device level
    input wire logic [20:0] pin_oe, // device enable
    input wire logic [20:0] pin_pu, // device pull-up
    input wire logic [20:0] host_en, // host drives
    input wire logic [20:0] host_val, // host level
    output logic [20:0] pin_lvl // wire level
);
    logic [20:0] last = 21'h0;
    always_ff @(posedge clk)
        last <= pin_lvl;
    always_comb
        for (int i = 0; i < 21; i++)
            if (pin_oe[i])
                pin_lvl[i] = pin_out[i];
            else if (host_en[i])
                pin_lvl[i] = host_val[i]; // rx rests high, handshake low asserts
            else if (i == 19)
                pin_lvl[i] = 1'b0; // board pull-down
            else if (pin_pu[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = ~last[i];
endmodule // pfs_board

// file: tb.sv
// Purpose: self-checking bench for the pin function select block
// Assumes: startup count cut to 20 cycles
// Notes: board model resolves the pins
`timescale 1ns/100ps
module tb;
    import pfs_pkg::*;
    localparam int SC = 20;
    logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic strap_n = 1'b1, mrst_n = 1'b1, script = 1'b0, txd = 1'b1, rts = 1'b0, pwm = 1'b0, tone = 1'b0;
    logic rxd, cts, ready, autorun, inter;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q, r, d, o, p, a;
    logic [20:0] pin_lvl, pout, poe, ppu, alt_out = 21'h0, alt_oe = 21'h0, h_en = 21'h0, h_val = 21'h0;
    logic [7:0] ra [6] = '{REG_DIR, REG_OUT_LVL, REG_PULL, REG_ALT, REG_WAVE, 8'h40};
    logic [31:0] re [6] = '{{11'h0, DIR_RST}, {11'h0, OUT_RST}, {11'h0, PULL_RST}, {11'h0, ALT_RST},
        {26'h0, WAVE_RST}, 32'h0};
    int mismatches = 0, cmp_count = 0, seed = 76565;
    always #5 clk = ~clk;
    pfs_pin_select #(.STARTUP_CYCLES(SC)) DUT (.CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PIN_IN(pin_lvl), .PIN_OUT(pout), .PIN_OE(poe), .PIN_PU(ppu), .RUN_MODE_STRAP_N(strap_n),
        .MODULE_RST_PIN_LOW(mrst_n), .SCRIPT_PRESENT(script), .UART_TXD(txd), .UART_RTS_ACT(rts),
        .PWM_IN(pwm), .TONE_IN(tone), .ALT_OUT(alt_out), .ALT_OE(alt_oe), .UART_RXD(rxd),
        .UART_CTS_ACT(cts), .READY(ready), .AUTORUN_GO(autorun), .INTERACTIVE(inter));
    pfs_board u_board (.clk(clk), .pin_out(pout), .pin_oe(poe), .pin_pu(ppu), .host_en(h_en),
        .host_val(h_val), .pin_lvl(pin_lvl));
    function automatic logic [31:0] exp_pu(input logic [31:0] dv, input logic [31:0] pv, input logic [31:0] av);
        return pv & ~dv & ~av & 32'h1FFFFF;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
            mismatches++;
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // request held until the edge that samples ack; ack is read before that edge's updates
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt, output logic [31:0] rv);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= dt;
        do
            @(posedge clk);
        while (ack !== 1'b1 && ++n < 20);
        if (n >= 20)
            mismatches++;
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        wb(1'b1, ad, dt, q);
    endtask
    task automatic chk_def();
        chk({11'h0, poe}, {11'h0, DIR_RST});
        chk({11'h0, pout}, {11'h0, OUT_RST});
        chk({11'h0, ppu}, {11'h0, PULL_RST & ~21'h014000});
        chk({31'h0, ready}, 32'h0);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk_def();
        foreach (ra[i])
        begin
            wb(1'b0, ra[i], 32'h0, r);
            chk(r, re[i]);
        end
        wb(1'b0, REG_PIN_IN, 32'h0, r);
        chk(r & 32'h80009, 32'h9);
        $display("done reset");
    endtask
    initial
    begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        do_reset();
        for (int k = 0; k < 8; k++)
        begin
            d = $random(seed);
            o = $random(seed);
            p = $random(seed);
            wr(REG_DIR, d);
            wr(REG_OUT_LVL, o);
            wr(REG_PULL, p);
            repeat (2) @(posedge clk);
            chk({11'h0, poe}, d & 32'h1FFFFF);
            chk({11'h0, pout & poe}, d & o & 32'h1FFFFF);
            chk({11'h0, ppu}, exp_pu(d, p, 32'h0));
        end
        wb(1'b0, REG_STATUS, 32'h0, r);
        chk(r & 32'h60, 32'h60);
        $display("done direction");
        a = ($random(seed) | 32'h2F) & 32'h1FFFFF;
        alt_oe <= 21'h20;
        h_en <= 21'h9;
        wr(REG_DIR, 32'h0);
        wr(REG_PULL, 32'h1FFFFF);
        wr(REG_ALT, a);
        for (int j = 0; j < 4; j++)
        begin
            txd <= j[0];
            rts <= j[1];
            h_val <= {17'h0, j[1], 2'h0, j[0]};
            repeat (6) @(posedge clk);
            chk({11'h0, ppu}, exp_pu(32'h0, 32'h1FFFFF, a));
            chk({30'h0, pout[2:1]}, {30'h0, ~j[1], j[0]});
            chk({30'h0, rxd, cts}, {30'h0, j[0], ~j[1]});
        end
        wr(REG_WAVE, 32'h2F);
        for (int j = 0; j < 2; j++)
        begin
            tone <= j[0];
            pwm <= ~j[0];
            alt_out <= {21{~j[0]}};
            repeat (3) @(posedge clk);
            chk({28'h0, pout[17], pout[13], pout[12], pout[5]}, {28'h0, j[0], ~j[0], j[0], ~j[0]});
            chk({11'h0, poe & 21'h023020}, 32'h23020);
        end
        $display("done alternate");
        for (int k = 1; k < 3; k++)
        begin
            wr(REG_DIR, $random(seed));
            wr(REG_CTRL, k);
            repeat (3) @(posedge clk);
            chk_def();
            repeat (SC + 4) @(posedge clk);
            chk({31'h0, ready}, 32'h1);
        end
        wr(REG_DIR, 32'hFF);
        // a low pulse well under the minimum must leave the configuration alone
        mrst_n <= 1'b0;
        repeat (20) @(posedge clk);
        mrst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({11'h0, poe}, 32'hFF);
        mrst_n <= 1'b0;
        repeat (60) @(posedge clk);
        mrst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_def();
        $display("done soft reset");
        for (int k = 0; k < 3; k++)
        begin
            strap_n <= (k == 2);
            script <= (k != 1);
            do_reset();
            chk({30'h0, autorun, inter}, {30'h0, k == 0, k == 2});
            repeat (SC) @(posedge clk);
            chk({31'h0, ready}, 32'h1);
        end
        $display("done strap");
        report_and_stop();
    end
endmodule // tb
